/* File: rtl/idt_decode.sv */
// Decode and execute of skip, XOR and extended instructions.
// Assumes INSTR is valid each cycle and FILE_DATA holds the addressed byte.
`timescale 1ns/1ps
`default_nettype none
module idt_decode (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic EXT_ENABLE_FUSE,
    input wire logic [15:0] INSTR,
    input wire logic NEXT_IS_TWO_WORD,
    input wire logic [7:0] FILE_DATA,
    input wire logic [3:0] BANK_SELECT_REG,
    input wire logic [20:0] PC,
    input wire logic [20:0] RETURN_STACK_TOP,
    input wire logic [7:0] PC_HIGH_LATCH,
    input wire logic [4:0] PC_UPPER_LATCH,
    output logic [7:0] ACC,
    output logic FLAG_N,
    output logic FLAG_Z,
    output logic [11:0] DATA_ADDR,
    output logic DATA_WE,
    output logic [7:0] DATA_WDATA,
    output logic [20:0] PC_LOAD,
    output logic PC_LOAD_EN,
    output logic [20:0] PUSH_ADDR,
    output logic PUSH_EN,
    output logic DISCARD,
    output logic ILLEGAL
);
    import idt_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        idt_state_t st;
        logic ext_en;
        logic [7:0] acc;
        logic n;
        logic z;
        logic [11:0] addr;
        logic we;
        logic [7:0] wdata;
        logic [20:0] pc_load;
        logic pc_en;
        logic [20:0] push_addr;
        logic push_en;
        logic discard;
        logic illegal;
        logic [11:0] move_src;
    } idt_core_t;
    idt_core_t s_r, s_nxt;

    logic [11:0] p0, p1, p2;
    logic [1:0] pw_sel;
    logic pw_en;
    logic [11:0] pw_data;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Byte-oriented operand address, shared by skip and file XOR forms
    function automatic logic [11:0] byte_addr(input logic [7:0] f, input logic a,
                                              input logic ext, input logic [3:0] bank,
                                              input logic [11:0] sp);
        logic [11:0] r;
        r = 12'h000;
        if (!a && ext && f <= IDX_LIMIT) r = sp + {4'h0, f};
        else if (!a) r = (f <= IDX_LIMIT) ? {4'h0, f} : {4'hF, f};
        else r = {bank, f};
        return r;
    endfunction

    function automatic logic [11:0] pick_ptr(input logic [1:0] sel, input logic [11:0] a,
                                             input logic [11:0] b, input logic [11:0] c);
        logic [11:0] r;
        r = c;
        if (sel == 2'h0) r = a;
        else if (sel == 2'h1) r = b;
        return r;
    endfunction

    idt_ptr_file idt_ptr_file_i (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .wr_sel(pw_sel),
        .wr_en(pw_en),
        .wr_data(pw_data),
        .ptr0(p0),
        .ptr1(p1),
        .ptr2(p2)
    );

    // ************************************************************
    // Decode
    // ************************************************************
    logic [7:0] xr_l, xr_f;
    logic [11:0] sel_ptr;
    always_comb begin
        s_nxt = s_r;
        s_nxt.we = 1'b0;
        s_nxt.pc_en = 1'b0;
        s_nxt.push_en = 1'b0;
        s_nxt.discard = 1'b0;
        s_nxt.illegal = 1'b0;
        pw_sel = 2'h0;
        pw_en = 1'b0;
        pw_data = 12'h000;
        xr_l = s_r.acc ^ INSTR[7:0];
        xr_f = s_r.acc ^ FILE_DATA;
        sel_ptr = pick_ptr(INSTR[7:6], p0, p1, p2);
        // Fuse only caught after reset release, never inside the reset branch
        s_nxt.ext_en = EXT_ENABLE_FUSE;
        unique case (s_r.st)
            IDT_FLUSH1: begin
                s_nxt.discard = 1'b1;
                s_nxt.st = NEXT_IS_TWO_WORD ? IDT_FLUSH2 : IDT_EXEC;
            end
            IDT_FLUSH2: begin
                s_nxt.discard = 1'b1;
                s_nxt.st = IDT_EXEC;
            end
            IDT_MOVE2: begin
                s_nxt.st = IDT_EXEC;
                if (INSTR[15:12] == OP_SECOND) begin
                    s_nxt.we = 1'b1;
                    s_nxt.wdata = FILE_DATA;
                    s_nxt.addr = s_r.move_src[11] ? (p2 + {5'h00, INSTR[6:0]})
                                                  : INSTR[11:0];
                end else begin
                    s_nxt.illegal = 1'b1;
                end
            end
            IDT_EXEC: begin
                if (INSTR[15:9] == OP_TSTZ) begin
                    s_nxt.addr = byte_addr(INSTR[7:0], INSTR[8], s_r.ext_en,
                                           BANK_SELECT_REG, p2);
                    if (FILE_DATA == 8'h00) s_nxt.st = IDT_FLUSH1;
                end else if (INSTR[15:8] == OP_XORL) begin
                    s_nxt.acc = xr_l;
                    s_nxt.n = xr_l[7];
                    s_nxt.z = (xr_l == 8'h00);
                end else if (INSTR[15:10] == OP_XORF) begin
                    s_nxt.addr = byte_addr(INSTR[7:0], INSTR[8], s_r.ext_en,
                                           BANK_SELECT_REG, p2);
                    s_nxt.n = xr_f[7];
                    s_nxt.z = (xr_f == 8'h00);
                    if (INSTR[9]) begin
                        s_nxt.we = 1'b1;
                        s_nxt.wdata = xr_f;
                    end else begin
                        s_nxt.acc = xr_f;
                    end
                end else if (!s_r.ext_en) begin
                    // Extended words raise ILLEGAL while the fuse is clear
                    s_nxt.illegal = (INSTR[15:10] == 6'h3A) || (INSTR == OP_CALL_VIA_ACCUM);
                end else if (INSTR[15:8] == OP_ADDP || INSTR[15:8] == OP_SUBP) begin
                    pw_en = 1'b1;
                    pw_sel = (INSTR[7:6] == RET_SEL) ? STACK_SEL : INSTR[7:6];
                    if (INSTR[7:6] == RET_SEL) sel_ptr = p2;
                    pw_data = INSTR[8] ? (sel_ptr - {6'h00, INSTR[5:0]})
                                       : (sel_ptr + {6'h00, INSTR[5:0]});
                    if (INSTR[7:6] == RET_SEL) begin
                        s_nxt.pc_en = 1'b1;
                        s_nxt.pc_load = RETURN_STACK_TOP;
                        s_nxt.st = IDT_FLUSH2;
                    end
                end else if (INSTR[15:8] == OP_PUSH) begin
                    s_nxt.we = 1'b1;
                    s_nxt.addr = p2;
                    s_nxt.wdata = INSTR[7:0];
                    pw_en = 1'b1;
                    pw_sel = STACK_SEL;
                    pw_data = p2 - 12'h001;
                end else if (INSTR == OP_CALL_VIA_ACCUM) begin
                    s_nxt.push_en = 1'b1;
                    s_nxt.push_addr = PC + PC_STEP;
                    s_nxt.pc_en = 1'b1;
                    s_nxt.pc_load = {PC_UPPER_LATCH, PC_HIGH_LATCH, s_r.acc};
                    s_nxt.st = IDT_FLUSH2;
                end else if (INSTR[15:8] == OP_MOVS) begin
                    s_nxt.addr = p2 + {5'h00, INSTR[6:0]};
                    s_nxt.move_src = {INSTR[7], 11'h000};
                    s_nxt.st = IDT_MOVE2;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r <= '0;
            s_r.st <= IDT_EXEC;
            s_r.acc <= ACC_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ACC = s_r.acc;
    assign FLAG_N = s_r.n;
    assign FLAG_Z = s_r.z;
    assign DATA_ADDR = s_r.addr;
    assign DATA_WE = s_r.we;
    assign DATA_WDATA = s_r.wdata;
    assign PC_LOAD = s_r.pc_load;
    assign PC_LOAD_EN = s_r.pc_en;
    assign PUSH_ADDR = s_r.push_addr;
    assign PUSH_EN = s_r.push_en;
    assign DISCARD = s_r.discard;
    assign ILLEGAL = s_r.illegal;

    // ************************************************************
    // Checks
    // ************************************************************
    logic byte_op;
    logic ext_op;
    assign byte_op = s_r.st == IDT_EXEC
        && (INSTR[15:9] == OP_TSTZ || INSTR[15:10] == OP_XORF);
    assign ext_op = s_r.st == IDT_EXEC && s_r.ext_en;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    a_skip_discard: assert property (s_r.st == IDT_EXEC && INSTR[15:9] == OP_TSTZ
        && FILE_DATA == 8'h00 |=> ##1 DISCARD) else $error("skip not discarded");
    a_noskip_keep: assert property (s_r.st == IDT_EXEC && INSTR[15:9] == OP_TSTZ
        && FILE_DATA != 8'h00 |=> ##1 !DISCARD) else $error("spurious discard");
    a_skip_twoword: assert property (s_r.st == IDT_FLUSH1 && NEXT_IS_TWO_WORD
        |=> ##1 DISCARD ##1 !DISCARD) else $error("two-word skip length");
    a_skip_oneword: assert property (s_r.st == IDT_FLUSH1 && !NEXT_IS_TWO_WORD
        |=> ##1 !DISCARD) else $error("one-word skip length");
    a_flush_quiet: assert property (s_r.st != IDT_EXEC && s_r.st != IDT_MOVE2
        |=> !DATA_WE && !PUSH_EN && !PC_LOAD_EN) else $error("flushed word acted");
    a_tstz_quiet: assert property (s_r.st == IDT_EXEC && INSTR[15:9] == OP_TSTZ
        |=> $stable(ACC) && $stable(FLAG_N) && $stable(FLAG_Z) && !DATA_WE)
        else $error("skip test changed state");

    a_bank_addr: assert property (byte_op && INSTR[8]
        |=> DATA_ADDR == {$past(BANK_SELECT_REG), $past(INSTR[7:0])})
        else $error("banked address wrong");
    a_access_low: assert property (byte_op && !INSTR[8] && !s_r.ext_en
        && INSTR[7:0] <= IDX_LIMIT |=> DATA_ADDR == {4'h0, $past(INSTR[7:0])})
        else $error("access bank low");
    a_access_high: assert property (byte_op && !INSTR[8] && INSTR[7:0] > IDX_LIMIT
        |=> DATA_ADDR == {4'hF, $past(INSTR[7:0])}) else $error("access bank high");
    a_index_addr: assert property (byte_op && !INSTR[8] && s_r.ext_en
        && INSTR[7:0] <= IDX_LIMIT
        |=> DATA_ADDR == $past(p2) + {4'h0, $past(INSTR[7:0])})
        else $error("indexed address");

    a_xorl_result: assert property (s_r.st == IDT_EXEC && INSTR[15:8] == OP_XORL
        |=> ACC == ($past(s_r.acc) ^ $past(INSTR[7:0])) && FLAG_Z == (ACC == 8'h00))
        else $error("literal xor wrong");
    a_xorl_neg: assert property (s_r.st == IDT_EXEC && INSTR[15:8] == OP_XORL
        |=> FLAG_N == ACC[7] && !DATA_WE) else $error("literal xor sign");
    a_xorf_dest: assert property (s_r.st == IDT_EXEC && INSTR[15:10] == OP_XORF
        && INSTR[9] |=> DATA_WE && $stable(ACC)) else $error("file xor dest");
    a_xorf_acc: assert property (s_r.st == IDT_EXEC && INSTR[15:10] == OP_XORF
        && !INSTR[9] |=> ACC == ($past(s_r.acc) ^ $past(FILE_DATA)) && !DATA_WE)
        else $error("file xor to acc");
    a_xorf_data: assert property (s_r.st == IDT_EXEC && INSTR[15:10] == OP_XORF
        && INSTR[9] |=> DATA_WDATA == ($past(s_r.acc) ^ $past(FILE_DATA)))
        else $error("file xor data");

    a_ext_off: assert property (!s_r.ext_en |=> !PUSH_EN) else $error("ext while off");
    a_ext_refused: assert property (s_r.st == IDT_EXEC && !s_r.ext_en
        && INSTR[15:10] == 6'h3A |=> ILLEGAL && !DATA_WE && !PC_LOAD_EN)
        else $error("ext not refused");

    a_addp_val: assert property (ext_op && INSTR[15:6] == 10'h3A0
        |=> p0 == $past(p0) + {6'h00, $past(INSTR[5:0])}) else $error("ptr add");
    a_ptr_flags: assert property (ext_op && INSTR[15:9] == 7'h74
        |=> $stable(ACC) && $stable(FLAG_N) && $stable(FLAG_Z)) else $error("pointer flags");
    a_ret_load: assert property (ext_op && INSTR[15:9] == 7'h74 && INSTR[7:6] == RET_SEL
        |=> PC_LOAD_EN ##1 DISCARD) else $error("return");
    a_addret_ptr: assert property (ext_op && INSTR[15:6] == 10'h3A3
        |=> p2 == $past(p2) + {6'h00, $past(INSTR[5:0])}) else $error("add return pointer");
    a_call_push: assert property (ext_op && INSTR == OP_CALL_VIA_ACCUM
        |=> PUSH_EN && PUSH_ADDR == $past(PC) + PC_STEP ##1 DISCARD)
        else $error("call push");
    a_call_target: assert property (ext_op && INSTR == OP_CALL_VIA_ACCUM
        |=> PC_LOAD == {$past(PC_UPPER_LATCH), $past(PC_HIGH_LATCH), $past(s_r.acc)}
        && $stable(FLAG_N) && $stable(FLAG_Z)) else $error("call target");
    a_move_write: assert property (s_r.st == IDT_MOVE2 && INSTR[15:12] == OP_SECOND
        |=> DATA_WE && DATA_WDATA == $past(FILE_DATA)) else $error("move write");
    a_move_bad: assert property (s_r.st == IDT_MOVE2 && INSTR[15:12] != OP_SECOND
        |=> ILLEGAL && !DATA_WE) else $error("bad second word");
    a_push_dec: assert property (ext_op && INSTR[15:8] == OP_PUSH
        |=> p2 == $past(p2) - 12'h001) else $error("push ptr");
    a_push_write: assert property (ext_op && INSTR[15:8] == OP_PUSH
        |=> DATA_WE && DATA_ADDR == $past(p2) && DATA_WDATA == $past(INSTR[7:0]))
        else $error("push write");
    a_subp_val: assert property (ext_op && INSTR[15:6] == 10'h3A4
        |=> p0 == $past(p0) - {6'h00, $past(INSTR[5:0])}) else $error("ptr sub");
    a_subret_ptr: assert property (ext_op && INSTR[15:6] == 10'h3A7
        |=> p2 == $past(p2) - {6'h00, $past(INSTR[5:0])} ##1 DISCARD)
        else $error("sub return pointer");
    a_ptr_sel: assert property (ext_op && INSTR[15:9] == 7'h74 && INSTR[7:6] == 2'h1
        |=> $stable(p0) && $stable(p2)) else $error("pointer select");

    // ************************************************************
    // Covers
    // ************************************************************
    c_skip: cover property (s_r.st == IDT_FLUSH2);
    c_move: cover property (s_r.st == IDT_MOVE2 ##1 DATA_WE);
    c_call: cover property (PUSH_EN);
    c_illegal: cover property (ILLEGAL);
    c_return: cover property (PC_LOAD_EN && !PUSH_EN);
endmodule
`default_nettype wire

/* File: rtl/idt_pkg.sv */
// Constants for the instruction decode tail of an 8-bit core.
// Assumes the core hands one fetched 16-bit word per instruction cycle.
package idt_pkg;
    localparam logic [6:0] OP_TSTZ = 7'h33;
    localparam logic [7:0] OP_XORL = 8'h0A;
    localparam logic [5:0] OP_XORF = 6'h06;
    localparam logic [7:0] OP_ADDP = 8'hE8;
    localparam logic [7:0] OP_SUBP = 8'hE9;
    localparam logic [7:0] OP_PUSH = 8'hEA;
    localparam logic [7:0] OP_MOVS = 8'hEB;
    localparam logic [15:0] OP_CALL_VIA_ACCUM = 16'h0014;
    localparam logic [3:0] OP_SECOND = 4'hF;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [1:0] STACK_SEL = 2'h2;
    localparam logic [1:0] RET_SEL = 2'h3;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [11:0] PTR_RESET = 12'h000;
    typedef enum logic [1:0] {IDT_EXEC, IDT_FLUSH1, IDT_FLUSH2, IDT_MOVE2} idt_state_t;
endpackage

/* File: rtl/idt_ptr_file.sv */
// Three 12-bit file pointers, each read straight from its register.
// Assumes one write per cycle from the decoder.
`timescale 1ns/1ps
`default_nettype none
module idt_ptr_file (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] wr_sel,
    input wire logic wr_en,
    input wire logic [11:0] wr_data,
    output logic [11:0] ptr0,
    output logic [11:0] ptr1,
    output logic [11:0] ptr2
);
    import idt_pkg::*;
    typedef struct packed {
        logic [11:0] p0;
        logic [11:0] p1;
        logic [11:0] p2;
    } idt_pf_t;
    idt_pf_t s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        if (wr_en && wr_sel == 2'h0) s_nxt.p0 = wr_data;
        if (wr_en && wr_sel == 2'h1) s_nxt.p1 = wr_data;
        if (wr_en && wr_sel == STACK_SEL) s_nxt.p2 = wr_data;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign ptr0 = s_r.p0;
    assign ptr1 = s_r.p1;
    assign ptr2 = s_r.p2;
endmodule
`default_nettype wire

/* File: tb/cpu_instr_decode_tail_tb.sv */
// Self-checking bench for the decode tail: skip, XOR and extended instructions.
// Assumes the decoder takes one word per rising edge and its outputs settle by 1 ns after it.
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_decode_tail_tb;
    import idt_pkg::*;
    // ********************
    // Signals and instance
    // ********************
    logic SYS_CLK = 1'b0, RESET_N = 1'b0, EXT_ENABLE_FUSE = 1'b0, NEXT_IS_TWO_WORD = 1'b0;
    logic [15:0] INSTR = 16'h0000;
    logic [7:0] FILE_DATA = 8'h00, PC_HIGH_LATCH = 8'h10;
    logic [3:0] BANK_SELECT_REG = 4'h3;
    logic [20:0] PC = 21'h001000, RETURN_STACK_TOP = 21'h012345;
    logic [4:0] PC_UPPER_LATCH = 5'h06;
    logic [7:0] ACC, DATA_WDATA;
    logic FLAG_N, FLAG_Z, DATA_WE, PC_LOAD_EN, PUSH_EN, DISCARD, ILLEGAL;
    logic [11:0] DATA_ADDR;
    logic [20:0] PC_LOAD, PUSH_ADDR;
    int n_errors = 0, comparisons = 0;
    logic [3:0] n_disc, n_we, n_pc, n_push, n_ill;
    logic [11:0] we_a;
    logic [7:0] we_d;
    logic [20:0] pc_v, push_v;
    always #5 SYS_CLK = ~SYS_CLK;
    idt_decode idt_decode_i (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
        .EXT_ENABLE_FUSE(EXT_ENABLE_FUSE), .INSTR(INSTR), .NEXT_IS_TWO_WORD(NEXT_IS_TWO_WORD),
        .FILE_DATA(FILE_DATA), .BANK_SELECT_REG(BANK_SELECT_REG), .PC(PC),
        .RETURN_STACK_TOP(RETURN_STACK_TOP), .PC_HIGH_LATCH(PC_HIGH_LATCH),
        .PC_UPPER_LATCH(PC_UPPER_LATCH), .ACC(ACC), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z),
        .DATA_ADDR(DATA_ADDR), .DATA_WE(DATA_WE), .DATA_WDATA(DATA_WDATA), .PC_LOAD(PC_LOAD),
        .PC_LOAD_EN(PC_LOAD_EN), .PUSH_ADDR(PUSH_ADDR), .PUSH_EN(PUSH_EN), .DISCARD(DISCARD),
        .ILLEGAL(ILLEGAL));
    // ********************
    // Shared tasks
    // ********************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One edge; pulses are tallied so that a one- or two-cycle offset does not matter
    task automatic tick;
        @(posedge SYS_CLK);
        #1;
        if (DISCARD === 1'b1) n_disc++;
        if (DATA_WE === 1'b1) begin
            n_we++;
            we_a = DATA_ADDR;
            we_d = DATA_WDATA;
        end
        if (PC_LOAD_EN === 1'b1) begin
            n_pc++;
            pc_v = PC_LOAD;
        end
        if (PUSH_EN === 1'b1) begin
            n_push++;
            push_v = PUSH_ADDR;
        end
        if (ILLEGAL === 1'b1) n_ill++;
    endtask
    // Words are followed by no-ops long enough to cover the longest flush
    task automatic op2(input logic [15:0] w1, input logic [15:0] w2, input logic [7:0] fd);
        {n_disc, n_we, n_pc, n_push, n_ill} = '0;
        INSTR = w1;
        FILE_DATA = fd;
        tick;
        INSTR = w2;
        tick;
        INSTR = 16'h0000;
        tick;
        tick;
        tick;
    endtask
    task automatic op(input logic [15:0] w, input logic [7:0] fd);
        op2(w, 16'h0000, fd);
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_xor;
        op(16'h0AB5, 8'h00);
        chk(ACC, 8'hB5, "xor literal");
        chk({FLAG_N, FLAG_Z}, 2'b10, "flags");
        op(16'h0AAF, 8'h00);
        chk(ACC, 8'h1A, "xor literal");
        op(16'h1B10, 8'hAF);
        chk(n_we, 1, "file write");
        chk({we_a, we_d}, {12'h310, 8'hB5}, "banked write");
        chk(ACC, 8'h1A, "acc kept");
        op(16'h1880, 8'h0F);
        chk({n_we, ACC}, {4'd0, 8'h15}, "xor to acc");
        chk(DATA_ADDR, 12'hF80, "access bank");
        op(16'h0A15, 8'h00);
        chk({FLAG_N, FLAG_Z}, 2'b01, "zero flag");
    endtask
    task automatic t_skip;
        op(16'h66FF, 8'h00);
        chk(n_disc, 1, "one flush");
        NEXT_IS_TWO_WORD = 1'b1;
        op(16'h66FF, 8'h00);
        chk(n_disc, 2, "two flushes");
        op(16'h66FF, 8'h01);
        chk(n_disc, 0, "no skip");
        NEXT_IS_TWO_WORD = 1'b0;
        op(16'hE823, 8'h00);
        chk(n_ill, 1, "fuse off");
    endtask
    task automatic t_ptr;
        EXT_ENABLE_FUSE = 1'b1;
        // Fuse is registered, so one idle edge before the first extended word
        tick;
        op(16'hE8A3, 8'h00);
        chk({n_ill, FLAG_Z}, {4'd0, 1'b1}, "pointer add");
        op(16'hE805, 8'h00);
        op(16'h1810, 8'h00);
        chk(DATA_ADDR, 12'h033, "indexed");
        op(16'h185F, 8'h00);
        chk(DATA_ADDR, 12'h082, "limit");
        op(16'h1860, 8'h00);
        chk(DATA_ADDR, 12'hF60, "above limit");
        op(16'hE983, 8'h00);
        chk(FLAG_Z, 1'b1, "flags kept");
        op(16'h1800, 8'h00);
        chk(DATA_ADDR, 12'h020, "pointer sub");
        op(16'hEA5A, 8'h00);
        chk({n_we, we_a, we_d}, {4'd1, 12'h020, 8'h5A}, "push");
        op(16'h1800, 8'h00);
        chk(DATA_ADDR, 12'h01F, "decrement");
        op(16'hE8C4, 8'h00);
        chk({n_pc, pc_v, n_disc}, {4'd1, 21'h012345, 4'd1}, "add return");
        op(16'h1800, 8'h00);
        chk(DATA_ADDR, 12'h023, "add return sum");
        op(16'hE9C2, 8'h00);
        chk({n_pc, pc_v, n_disc}, {4'd1, 21'h012345, 4'd1}, "sub return");
        op(16'h1800, 8'h00);
        chk(DATA_ADDR, 12'h021, "sub return diff");
    endtask
    task automatic t_call_move;
        op(16'h0A80, 8'h00);
        op(16'h0014, 8'h00);
        chk({n_push, push_v}, {4'd1, 21'h001002}, "return push");
        chk({n_pc, pc_v}, {4'd1, 21'h061080}, "call target");
        chk({n_disc, FLAG_N, FLAG_Z}, {4'd1, 2'b10}, "call cycles");
        op2(16'hEB05, 16'hF123, 8'h99);
        chk({n_we, we_a, we_d}, {4'd1, 12'h123, 8'h99}, "move to file");
        op2(16'hEB85, 16'hF006, 8'h44);
        chk({n_we, we_a, we_d}, {4'd1, 12'h027, 8'h44}, "move to stack");
        op2(16'hEB05, 16'h1234, 8'h00);
        chk({n_ill, n_we}, {4'd1, 4'd0}, "bad second word");
    endtask
    // ********************
    // Main sequence and watchdog
    // ********************
    initial begin
        #50000;
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge SYS_CLK);
        chk({ACC, DATA_WE, PC_LOAD_EN, PUSH_EN, ILLEGAL}, 12'h000, "reset values");
        #1;
        RESET_N = 1'b1;
        t_xor;
        t_skip;
        t_ptr;
        t_call_move;
        wrap_up;
    end
endmodule
`default_nettype wire
